// file: verilog/rmw_engine.sv
// Bit read-modify-write and block byte move engine with its target space
// Notes on behaviour
// [R01] Writes to unmapped addresses store nothing; the byte is dropped.
// [R02] Reads from unmapped addresses return an undefined, here fixed, value.
// [R03] Block move copies count bytes from source pointer to destination pointer.
// [R04] Software keeps the last destination address at or below FFFF.
// [R05] Bit ops read a byte, change one bit, write the byte back.
// [R06] Timer address reads the running count and writes the reload value.
// [R07] Port data reads give pin level for inputs, latch for outputs.
// [R08] Software should modify a memory copy of the port latch, then write it.
// [R09] Bit ops take the target bit number from a 3-bit field.
// [R10] The write-only direction register reads back as all ones.
// [R11] Read and write halves are two back-to-back byte cycles to one address.
module rmw_engine
   import rmw_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        srst,
   // Command request
   input  wire logic        cmd_valid,
   output logic             cmd_ready,
   input  wire op_t         cmd_op,
   input  wire logic [15:0] cmd_addr,
   input  wire logic [7:0]  cmd_wdata,
   input  wire logic [2:0]  cmd_bit,
   input  wire logic        cmd_carry,
   input  wire logic [7:0]  move_count_reg,
   input  wire logic [15:0] move_source_ptr,
   input  wire logic [15:0] move_dest_ptr,
   output logic             cmd_done,
   // Read answers
   output logic             rsp_valid,
   input  wire logic        rsp_ready,
   output logic [7:0]       rsp_data,
   // Port pins
   input  wire logic [7:0]  pin_in,
   output logic [7:0]       pin_out,
   output logic [7:0]       pin_oe
);
   // =====================================
   // Engine state
   state_t      state;
   op_t         op;
   logic [15:0] addr;
   logic [15:0] dst;
   logic [7:0]  count;
   logic [7:0]  hold;
   logic [2:0]  bitn;
   logic        carry;
   logic        done_q;
   // Target space
   logic [7:0]  ram [RAM_BYTES];
   logic [7:0]  port_output_latch;
   logic [7:0]  port_direction_reg;
   logic [7:0]  tmr_count;
   logic [7:0]  tmr_reload;
   logic [3:0]  tmr_div;
   logic [7:0]  pin_meta;
   logic [7:0]  pin_sync;
   // Two-entry answer buffer
   logic [7:0]  fifo [2];
   logic        wr_ptr;
   logic        rd_ptr;
   logic [1:0]  fill;

   // =====================================
   // Address decode
   logic        bus_rd;
   logic        bus_wr;
   logic [15:0] bus_addr;
   logic [7:0]  bus_wdata;
   logic [7:0]  bus_rdata;
   logic        hit_ram;
   logic        hit_tmr;
   logic        hit_pdat;
   logic        hit_pdir;
   logic [7:0]  port_read;
   logic [7:0]  bit_mask;
   logic [7:0]  modified;
   logic        fifo_full;
   logic        push;
   logic        pop;
   logic        tmr_tick;

   assign hit_ram  = (bus_addr[15:RAM_AW] == RAM_BASE[15:RAM_AW]);
   assign hit_tmr  = (bus_addr == TMR_ADDR);
   assign hit_pdat = (bus_addr == PDAT_ADDR);
   assign hit_pdir = (bus_addr == PDIR_ADDR);

   // Bus requests come only from the engine states
   assign bus_rd    = (state == S_READ) || (state == S_MVRD);
   assign bus_wr    = (state == S_WRITE) || (state == S_MVWR);
   assign bus_addr  = (state == S_MVWR) ? dst : addr;
   assign bus_wdata = (state == S_MVWR) ? hold : modified;

   // [R07] pin or latch per bit
   assign port_read = (port_direction_reg & port_output_latch) | (~port_direction_reg & pin_sync);

   // Read mux; timer address shows the live count, direction shows ones
   // [R02] [R06] [R10] read side of the map
   assign bus_rdata = hit_ram  ? ram[bus_addr[RAM_AW-1:0]] :
                      hit_tmr  ? tmr_count :
                      hit_pdat ? port_read :
                      hit_pdir ? BYTE_ONES : EMPTY_READ;

   // [R05] [R09] one-bit change selected by the 3-bit field
   assign bit_mask = 8'h01 << bitn;
   assign modified = (op == OP_WRITE) ? hold :
                     (op == OP_BIT_SET_OP)  ? (hold | bit_mask) :
                     (op == OP_BIT_CLEAR_OP)  ? (hold & ~bit_mask) :
                     (op == OP_BIT_INVERT_OP)  ? (hold ^ bit_mask) :
                     (op == OP_BST)   ? (carry ? (hold | bit_mask) : (hold & ~bit_mask)) :
                     (carry ? (hold & ~bit_mask) : (hold | bit_mask));

   // Reads stall while the answer buffer is full, so no answer is lost
   assign fifo_full = (fill == 2'h2);
   assign push      = (state == S_READ) && (op == OP_READ);
   assign pop       = rsp_valid && rsp_ready;
   assign cmd_ready = (state == S_IDLE) && !fifo_full;
   assign rsp_valid = (fill != 2'h0);
   assign rsp_data  = fifo[rd_ptr];
   assign cmd_done  = done_q;
   assign pin_out   = port_output_latch;
   assign pin_oe    = port_direction_reg;
   assign tmr_tick  = (tmr_div == TMR_DIV - 4'h1);

   // =====================================
   // Sequencer
   always_ff @(posedge ref_clk)
   begin
      done_q <= 1'b0;
      if (srst)
      begin
         state <= S_IDLE;
         op    <= OP_READ;
         addr  <= 16'h0000;
         dst   <= 16'h0000;
         count <= BYTE_ZERO;
         hold  <= BYTE_ZERO;
         bitn  <= 3'h0;
         carry <= 1'b0;
      end
      else
      begin
         case (state)
            S_IDLE:
               if (cmd_valid && cmd_ready)
               begin
                  op    <= cmd_op;
                  addr  <= (cmd_op == OP_MOVE) ? move_source_ptr : cmd_addr;
                  dst   <= move_dest_ptr;
                  count <= move_count_reg;
                  hold  <= cmd_wdata;
                  bitn  <= cmd_bit;
                  carry <= cmd_carry;
                  if (cmd_op == OP_MOVE)
                  begin
                     state  <= (move_count_reg == BYTE_ZERO) ? S_IDLE : S_MVRD;
                     done_q <= (move_count_reg == BYTE_ZERO);
                  end
                  else
                     state <= (cmd_op == OP_WRITE) ? S_WRITE : S_READ;
               end
            // [R11] write half follows the read half at once
            S_READ:
            begin
               hold   <= bus_rdata;
               state  <= (op == OP_READ) ? S_IDLE : S_WRITE;
               done_q <= (op == OP_READ);
            end
            S_WRITE:
            begin
               state  <= S_IDLE;
               done_q <= 1'b1;
            end
            // [R03] one byte per read and write pair
            S_MVRD:
            begin
               hold  <= bus_rdata;
               state <= S_MVWR;
            end
            // [R04] destination relies on software to avoid wrapping
            S_MVWR:
            begin
               addr   <= addr + 16'h0001;
               dst    <= dst + 16'h0001;
               count  <= count - 8'h01;
               state  <= (count == 8'h01) ? S_IDLE : S_MVRD;
               done_q <= (count == 8'h01);
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   // =====================================
   // Target space writes
   // [R01] unmapped writes fall through every decode and are dropped
   always_ff @(posedge ref_clk)
   begin
      if (bus_wr && hit_ram)
         ram[bus_addr[RAM_AW-1:0]] <= bus_wdata;
   end

   // [R06] timer address writes only reach the reload register
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         port_output_latch  <= BYTE_ZERO;
         port_direction_reg <= BYTE_ZERO;
         tmr_reload         <= BYTE_ZERO;
      end
      else if (bus_wr)
      begin
         if (hit_pdat)
            port_output_latch <= bus_wdata;
         if (hit_pdir)
            port_direction_reg <= bus_wdata;
         if (hit_tmr)
            tmr_reload <= bus_wdata;
      end
   end

   // Timer counts up on the prescaled tick and reloads on overflow
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         tmr_div   <= 4'h0;
         tmr_count <= BYTE_ZERO;
      end
      else
      begin
         tmr_div <= tmr_tick ? 4'h0 : tmr_div + 4'h1;
         if (tmr_tick)
            tmr_count <= (tmr_count == BYTE_ONES) ? tmr_reload : tmr_count + 8'h01;
      end
   end

   // Pin synchroniser; only the second stage is read
   always_ff @(posedge ref_clk)
   begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
   end

   // Answer buffer
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         fill   <= 2'h0;
      end
      else
      begin
         if (push)
         begin
            fifo[wr_ptr] <= bus_rdata;
            wr_ptr       <= ~wr_ptr;
         end
         if (pop)
            rd_ptr <= ~rd_ptr;
         fill <= fill + {1'b0, push} - {1'b0, pop};
      end
   end

   // =====================================
   // Checks
   property p_rmw_pair;
      @(posedge ref_clk) disable iff (srst)
      (state == S_READ && op != OP_READ) |=> (bus_wr && bus_addr == $past(bus_addr));
   endproperty
   a_rmw_pair: assert property (p_rmw_pair) else $error("rmw write half missing"); // [R11]

   property p_one_bit;
      @(posedge ref_clk) disable iff (srst)
      (state == S_READ && op != OP_READ && op != OP_WRITE)
      |=> ((bus_wdata ^ $past(bus_rdata)) & ~bit_mask) == 8'h00;
   endproperty
   a_one_bit: assert property (p_one_bit) else $error("other bits changed"); // [R05]

   property p_bit_set_op_bit;
      @(posedge ref_clk) disable iff (srst)
      (cmd_valid && cmd_ready && cmd_op == OP_BIT_SET_OP) |-> ##2 (bus_wr && bus_wdata[bitn]);
   endproperty
   a_bit_set_op_bit: assert property (p_bit_set_op_bit) else $error("selected bit not set"); // [R09]

   property p_dir_ones;
      @(posedge ref_clk) disable iff (srst)
      (bus_rd && hit_pdir) |-> bus_rdata == 8'hFF;
   endproperty
   a_dir_ones: assert property (p_dir_ones) else $error("direction read not ones"); // [R10]

   property p_port_mix;
      @(posedge ref_clk) disable iff (srst)
      (bus_rd && hit_pdat) |-> bus_rdata == ((pin_oe & pin_out) | (~pin_oe & pin_sync));
   endproperty
   a_port_mix: assert property (p_port_mix) else $error("port read mix wrong"); // [R07]

   property p_tmr_split;
      @(posedge ref_clk) disable iff (srst)
      (bus_wr && hit_tmr && !tmr_tick) |=> (tmr_reload == $past(bus_wdata))
      && (tmr_count == $past(tmr_count));
   endproperty
   a_tmr_split: assert property (p_tmr_split) else $error("timer write hit counter"); // [R06]

   property p_empty_write;
      @(posedge ref_clk) disable iff (srst)
      (bus_wr && !hit_ram && !hit_tmr && !hit_pdat && !hit_pdir)
      |=> $stable(port_output_latch) && $stable(port_direction_reg) && $stable(tmr_reload);
   endproperty
   a_empty_write: assert property (p_empty_write) else $error("unmapped write stored"); // [R01]

   property p_empty_read;
      @(posedge ref_clk) disable iff (srst)
      (bus_rd && !hit_ram && !hit_tmr && !hit_pdat && !hit_pdir) |-> bus_rdata == 8'h00;
   endproperty
   a_empty_read: assert property (p_empty_read) else $error("unmapped read value"); // [R02]

   property p_move_step;
      @(posedge ref_clk) disable iff (srst)
      (state == S_MVRD) |=> (bus_wr && bus_wdata == $past(bus_rdata))
      ##1 (dst == $past(dst) + 16'h0001 && count == $past(count) - 8'h01);
   endproperty
   a_move_step: assert property (p_move_step) else $error("move step wrong"); // [R03]
endmodule : rmw_engine

// file: verilog/rmw_pkg.sv
// Constants for the bit read-modify-write and block move engine
package rmw_pkg;
   // =====================================
   // Address map of the target space
   localparam logic [15:0] RAM_BASE  = 16'hFE00;
   localparam logic [15:0] TMR_ADDR  = 16'hFFB0;
   localparam logic [15:0] PDAT_ADDR = 16'hFFD8;
   localparam logic [15:0] PDIR_ADDR = 16'hFFE8;
   localparam int          RAM_BYTES = 256;
   localparam int          RAM_AW    = 8;
   // =====================================
   // Reset values and read patterns
   localparam logic [7:0]  BYTE_ZERO  = 8'h00;
   localparam logic [7:0]  BYTE_ONES  = 8'hFF;
   localparam logic [7:0]  EMPTY_READ = 8'h00;
   // =====================================
   // Timer prescale: one count per TMR_DIV cycles
   localparam logic [3:0]  TMR_DIV = 4'h8;
   // =====================================
   // Command codes
   typedef enum logic [2:0] {
      OP_READ  = 3'h0,
      OP_WRITE = 3'h1,
      OP_BIT_SET_OP  = 3'h2,
      OP_BIT_CLEAR_OP  = 3'h3,
      OP_BIT_INVERT_OP  = 3'h4,
      OP_BST   = 3'h5,
      OP_BIT_STORE_INV_CARRY_OP  = 3'h6,
      OP_MOVE  = 3'h7
   } op_t;
   // Engine states; one bit changes per step except S_IDLE to S_WRITE and back to S_IDLE from S_WRITE or S_MVWR
   typedef enum logic [2:0] {
      S_IDLE = 3'h0,
      S_READ = 3'h1,
      S_WRITE = 3'h3,
      S_MVRD = 3'h2,
      S_MVWR = 3'h6
   } state_t;
endpackage : rmw_pkg

// file: bench/pin_far.sv
// Far-side pin model that resolves the port wires from the drive enables
module pin_far
(
   // Drive from the engine
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe,
   // Outside levels and the resolved wire
   input  wire logic [7:0] ext_level,
   output logic [7:0]      pin_in
);
   timeunit 1ns;
   timeprecision 1ns;
   // Driven bits follow the latch; released bits take the outside level
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : pin_far

// file: bench/rmw_engine_test.sv
// Self-checking bench for the bit read-modify-write and block move engine
module rmw_engine_test;
   timeunit 1ns;
   timeprecision 1ns;
   import rmw_pkg::*;
   // =====================================
   // Stimulus and observed signals
   logic        ref_clk = 1'b0;
   logic        srst = 1'b1;
   logic        cmd_valid = 1'b0;
   logic        cmd_carry = 1'b0;
   logic        rsp_ready = 1'b1;
   op_t         cmd_op = OP_READ;
   logic [15:0] cmd_addr = 16'h0000;
   logic [15:0] move_source_ptr = 16'hFE00;
   logic [15:0] move_dest_ptr = 16'hFE80;
   logic [7:0]  cmd_wdata = 8'h00;
   logic [7:0]  move_count_reg = 8'h03;
   logic [7:0]  ext_level = 8'h40;
   logic [2:0]  cmd_bit = 3'h0;
   logic        cmd_ready;
   logic        cmd_done;
   logic        rsp_valid;
   logic [7:0]  rsp_data;
   logic [7:0]  pin_in;
   logic [7:0]  pin_out;
   logic [7:0]  pin_oe;
   logic [7:0]  got;
   logic [7:0]  lat;
   int          error_cnt = 0;
   int          samples_checked = 0;

   rmw_engine i_rmw_engine (.ref_clk(ref_clk), .srst(srst), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
      .cmd_bit(cmd_bit), .cmd_carry(cmd_carry), .move_count_reg(move_count_reg),
      .move_source_ptr(move_source_ptr), .move_dest_ptr(move_dest_ptr),
      .cmd_done(cmd_done), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
      .rsp_data(rsp_data), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
   pin_far i_pin_far (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
      .pin_in(pin_in));

   // 10 MHz clock
   initial
   begin
      forever #50 ref_clk = ~ref_clk;
   end
   // =====================================
   // Shared tasks
   task automatic check8(input logic [7:0] act, input logic [7:0] exp, input string what);
      samples_checked++;
      if (act !== exp)
      begin
         error_cnt++;
         $display("mismatch at %0t: %s got %h want %h", $time, what, act, exp);
      end
   endtask : check8
   // Offers a command at a falling edge, holds it until taken, then counts cycles to done
   task automatic issue(input op_t op, input logic [15:0] a, input logic [7:0] d,
                        input logic [2:0] b, input logic c);
      int n;
      n = 0;
      // Unanswered reads leave an unknown byte, so a stale answer cannot pass
      got = 8'hXX;
      @(negedge ref_clk);
      cmd_op = op;
      cmd_addr = a;
      cmd_wdata = d;
      cmd_bit = b;
      cmd_carry = c;
      cmd_valid = 1'b1;
      while (cmd_ready !== 1'b1 && n < 50)
      begin
         @(negedge ref_clk);
         n++;
      end
      @(negedge ref_clk);
      cmd_valid = 1'b0;
      lat = 8'h01;
      while (cmd_done !== 1'b1 && lat < 8'hF0)
      begin
         if (rsp_valid === 1'b1 && rsp_ready === 1'b1) got = rsp_data;
         @(negedge ref_clk);
         lat++;
      end
      if (rsp_valid === 1'b1 && rsp_ready === 1'b1) got = rsp_data;
      // A command that is never taken or never finishes counts as a mismatch
      if (n >= 50 || lat >= 8'hF0)
      begin
         error_cnt++;
         $display("mismatch at %0t: command timed out", $time);
      end
   endtask : issue
   task automatic rd(input logic [15:0] a);
      issue(OP_READ, a, 8'h00, 3'h0, 1'b0);
   endtask : rd
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      issue(OP_WRITE, a, d, 3'h0, 1'b0);
   endtask : wr
   // =====================================
   // Scenarios
   task automatic t_space;
      wr(16'hFE05, 8'h5A);
      rd(16'hFE05);
      check8(got, 8'h5A, "ram");
      wr(16'h1234, 8'h5A);
      rd(16'h1234);
      check8(got, EMPTY_READ, "unmapped");
      $display("test space done");
   endtask : t_space
   task automatic t_bitops;
      op_t         ops[7] = '{OP_BIT_SET_OP, OP_BIT_CLEAR_OP, OP_BIT_INVERT_OP, OP_BST, OP_BIT_STORE_INV_CARRY_OP, OP_BST, OP_BIT_STORE_INV_CARRY_OP};
      logic [2:0]  bits[7] = '{3'h1, 3'h7, 3'h0, 3'h4, 3'h5, 3'h1, 3'h3};
      logic        cy[7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
      logic [7:0]  exp[7] = '{8'hA7, 8'h27, 8'h26, 8'h36, 8'h16, 8'h14, 8'h1C};
      wr(16'hFE40, 8'hA5);
      // Both carry levels reach the two store operations
      for (int i = 0; i < 7; i++)
      begin
         issue(ops[i], 16'hFE40, 8'h00, bits[i], cy[i]);
         check8(lat, 8'h03, "bit op cycles");
         rd(16'hFE40);
         check8(got, exp[i], "bit op");
      end
      $display("test bitops done");
   endtask : t_bitops
   // Pins 7 and 6 are inputs held low and high while the rest drive
   task automatic t_port;
      wr(PDIR_ADDR, 8'h3F);
      wr(PDAT_ADDR, 8'h80);
      check8(pin_oe, 8'h3F, "direction");
      issue(OP_BIT_SET_OP, PDAT_ADDR, 8'h00, 3'h0, 1'b0);
      check8(pin_out, 8'h41, "latch after set");
      rd(PDAT_ADDR);
      check8(got, 8'h41, "port read");
      rd(PDIR_ADDR);
      check8(got, BYTE_ONES, "direction read");
      issue(OP_BIT_CLEAR_OP, PDIR_ADDR, 8'h00, 3'h0, 1'b0);
      check8(pin_oe, 8'hFE, "direction after clear");
      wr(16'hFE20, 8'h80); // latch copy kept in memory
      issue(OP_BIT_SET_OP, 16'hFE20, 8'h00, 3'h0, 1'b0);
      rd(16'hFE20);
      wr(PDAT_ADDR, got);
      check8(pin_out, 8'h81, "latch from copy");
      $display("test port done");
   endtask : t_port
   // Destination stays well below the top of the space
   task automatic t_move;
      wr(16'hFE00, 8'h11);
      wr(16'hFE01, 8'h22);
      wr(16'hFE02, 8'h33);
      issue(OP_MOVE, 16'h0000, 8'h00, 3'h0, 1'b0);
      check8(lat, 8'h07, "move cycles");
      for (int i = 0; i < 3; i++)
      begin
         rd(16'hFE80 + 16'(i));
         check8(got, 8'h11 * 8'(i + 1), "moved byte");
      end
      move_count_reg = 8'h00;
      issue(OP_MOVE, 16'h0000, 8'h00, 3'h0, 1'b0);
      check8(lat, 8'h01, "empty move");
      $display("test move done");
   endtask : t_move
   // Reload write must leave the running count alone
   task automatic t_timer;
      logic [7:0] first;
      rd(TMR_ADDR);
      first = got;
      wr(TMR_ADDR, 8'hC0);
      rd(TMR_ADDR);
      check8(8'(got - first <= 8'h01), 8'h01, "count kept");
      // Bit op on the shared address writes count bits into the reload only
      issue(OP_BIT_SET_OP, TMR_ADDR, 8'h00, 3'h7, 1'b0);
      check8(lat, 8'h03, "timer bit op cycles");
      rd(TMR_ADDR);
      check8(got & 8'h80, 8'h00, "count bit untouched");
      $display("test timer done");
   endtask : t_timer
   // Receiver stalls until both buffer entries are full
   task automatic t_stall;
      rsp_ready = 1'b0;
      rd(16'hFE00);
      rd(16'hFE01);
      @(negedge ref_clk);
      check8(8'(cmd_ready), 8'h00, "full buffer refuses");
      check8(rsp_data, 8'h11, "head answer");
      rsp_ready = 1'b1;
      @(negedge ref_clk);
      check8(rsp_data, 8'h22, "second answer");
      @(negedge ref_clk);
      check8(8'(rsp_valid), 8'h00, "buffer empty");
      $display("test stall done");
   endtask : t_stall
   // =====================================
   // Verdict and run control
   task automatic summarize;
      $display("checked %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : summarize
   // Main sequence
   initial
   begin
      repeat (2) @(negedge ref_clk);
      srst = 1'b0;
      t_timer();
      t_space();
      t_bitops();
      t_port();
      t_move();
      t_stall();
      summarize();
   end
   // Watchdog well beyond the roughly 150 cycles the tests need
   initial
   begin
      #2000000;
      error_cnt++;
      summarize();
   end
endmodule : rmw_engine_test
